// File: design/ctp_regs.vh
// constants for the cascadable timer pair
`ifndef CTP_REGS_VH
`define CTP_REGS_VH
// control word field positions (per 16-bit timer)
`define CTP_CTL_ON        0
`define CTP_CTL_GATE      1
`define CTP_CTL_CS        2
`define CTP_CTL_PS_LO     3
`define CTP_CTL_PS_HI     4
`define CTP_CTL_T32       5
`define CTP_CTL_IDLESTOP  6
`define CTP_CTL_W         16
`define CTP_CTL_RST       16'h0000
// prescale selects 1:1, 1:8, 1:64, 1:256
`define CTP_PS_1          2'h0
`define CTP_PS_8          2'h1
`define CTP_PS_64         2'h2
`define CTP_PS_256        2'h3
`define CTP_PS_MAX8       8'h07
`define CTP_PS_MAX64      8'h3f
`define CTP_PS_MAX256     8'hff
`define CTP_CNT_RST       16'h0000
`define CTP_PR_RST        16'hffff
`endif

// File: design/ctp_prescaler.v
// selectable prescaler producing one count tick per divided clock
`timescale 1ns/1ps
`include "ctp_regs.vh"
module ctp_prescaler (
  // clock and reset
  input  wire       clk,
  input  wire       rst,
  // control
  input  wire       clr,
  input  wire [1:0] ps_sel,
  input  wire       src_tick,
  // tick out
  output reg        tick
);
  reg  [7:0] div_ff;
  reg  [7:0] lim;

  always @* begin
    case (ps_sel)
      `CTP_PS_8:  lim = `CTP_PS_MAX8;
      `CTP_PS_64: lim = `CTP_PS_MAX64;
      `CTP_PS_256: lim = `CTP_PS_MAX256;
      default:    lim = 8'h00;
    endcase
  end

  always @(posedge clk) begin
    if (rst || clr) begin
      div_ff <= 8'h00;
      tick   <= 1'b0;
    end else begin
      tick <= 1'b0;
      if (src_tick) begin
        if (div_ff >= lim) begin
          div_ff <= 8'h00;
          tick   <= 1'b1;
        end else begin
          div_ff <= div_ff + 8'h01;
        end
      end
    end
  end
endmodule // ctp_prescaler

// File: design/ctp_count_src.v
// count source: internal clock or external edge, with gating
`timescale 1ns/1ps
`include "ctp_regs.vh"
module ctp_count_src (
  // clock and reset
  input  wire clk,
  input  wire rst,
  // control
  input  wire on,
  input  wire gate_en,
  input  wire ext_sel,
  // pins
  input  wire ext_clk,
  input  wire gate_in,
  // source tick
  output reg  src_tick,
  output reg  gate_fall
);
  reg ext_ff;
  reg gate_ff;

  always @(posedge clk) begin
    if (rst) begin
      ext_ff    <= 1'b0;
      gate_ff   <= 1'b0;
      src_tick  <= 1'b0;
      gate_fall <= 1'b0;
    end else begin
      ext_ff    <= ext_clk;
      gate_ff   <= gate_in;
      gate_fall <= on && gate_en && gate_ff && !gate_in;
      if (!on)
        src_tick <= 1'b0;
      else if (ext_sel)
        // synchronous counter: rising edge of pin
        src_tick <= ext_clk && !ext_ff;
      else if (gate_en)
        // gated accumulation: count while gate high
        src_tick <= gate_in;
      else
        src_tick <= 1'b1;
    end
  end
endmodule // ctp_count_src

// File: design/ctp_timer_pairs.v
// two cascadable timer pairs with triggers and dma requests
`timescale 1ns/1ps
`include "ctp_regs.vh"
// Behaviour
// - pair runs as 32-bit or two 16-bit
// - modes: dual 16, 32 timer, 32 counter
// - 16-bit halves: all synchronous modes
// - each timer synchronous timer or counter
// - low timer lsw, high timer msw
// - 32-bit: high control ignored
// - 32-bit: clock and gate from low
// - 32-bit interrupt on high flag
// - interrupt on 32-bit period match
// - gated mode qualifies counting by gate
// - selectable prescaler divides count clock
// - keeps running in sleep; in idle unless idle stop set
// - only pair a feeds capture/compare
// - converter trigger: pair a high timer or pair a 32-bit
// - every timer raises dma requests, except the low half of a 32-bit pair
module ctp_timer_pairs (
  // clock and reset
  input  wire        CLK,
  input  wire        SYS_RST,
  // power state
  input  wire        IDLE_MODE,
  // control words: a low, a high, b low, b high
  input  wire [15:0] PAIR_A_LOW_CONTROL,
  input  wire [15:0] PAIR_A_HIGH_CONTROL,
  input  wire [15:0] PAIR_B_LOW_CONTROL,
  input  wire [15:0] PAIR_B_HIGH_CONTROL,
  // period values per timer
  input  wire [63:0] PERIOD,
  // external clock and gate pins per timer
  input  wire [3:0]  EXT_CLK,
  input  wire [3:0]  GATE_IN,
  // counts and flags
  output reg  [63:0] COUNT,
  output reg  [3:0]  IRQ_FLAG,
  output reg  [3:0]  DMA_REQ,
  // capture/compare time base, pair a only
  output reg         CC_TICK_A_LOW,
  output reg         CC_TICK_A_HIGH,
  // converter trigger
  output reg         CONV_TRIG
);
  ////////////////////////////////////////////////////////////////////////
  wire [63:0] ctl_all = {PAIR_B_HIGH_CONTROL, PAIR_B_LOW_CONTROL,
                         PAIR_A_HIGH_CONTROL, PAIR_A_LOW_CONTROL};
  wire [1:0]  mode32;
  wire [3:0]  run;
  wire [3:0]  src_tick;
  wire [3:0]  gate_fall;
  wire [3:0]  cnt_tick;
  reg  [3:0]  match;
  reg  [3:0]  nxt_irq;
  reg  [63:0] nxt_count;

  assign mode32[0] = PAIR_A_LOW_CONTROL[`CTP_CTL_T32];
  assign mode32[1] = PAIR_B_LOW_CONTROL[`CTP_CTL_T32];

  ////////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_tmr
      // in 32-bit mode the high half borrows the low half's control
      // index stays in range for every g, also in the unused branch
      wire [15:0] c = (g % 2 == 1 && mode32[g/2]) ?
                      ctl_all[(g - g % 2)*16 +: 16] :
                      ctl_all[g*16 +: 16];
      // idle stop only honoured in idle; sleep never halts us
      assign run[g] = c[`CTP_CTL_ON] &&
                      !(IDLE_MODE && c[`CTP_CTL_IDLESTOP]);
      ctp_count_src u_src (
        .clk       (CLK),
        .rst       (SYS_RST),
        .on        (run[g]),
        .gate_en   (c[`CTP_CTL_GATE]),
        .ext_sel   (c[`CTP_CTL_CS]),
        .ext_clk   (EXT_CLK[g]),
        .gate_in   (GATE_IN[g]),
        .src_tick  (src_tick[g]),
        .gate_fall (gate_fall[g])
      );
      ctp_prescaler u_ps (
        .clk      (CLK),
        .rst      (SYS_RST),
        .clr      (!run[g]),
        .ps_sel   (c[`CTP_CTL_PS_HI:`CTP_CTL_PS_LO]),
        .src_tick (src_tick[g]),
        .tick     (cnt_tick[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  integer p;
  reg [31:0] cnt32;
  reg [31:0] pr32;
  always @* begin
    nxt_count = COUNT;
    match     = 4'h0;
    cnt32     = 32'h0;
    pr32      = 32'h0;
    for (p = 0; p < 2; p = p + 1) begin
      if (mode32[p]) begin
        // low word in the low timer, high word in the high timer
        cnt32 = {COUNT[p*32+16 +: 16], COUNT[p*32 +: 16]};
        pr32  = {PERIOD[p*32+16 +: 16], PERIOD[p*32 +: 16]};
        // driven only by the low timer's tick path
        if (cnt_tick[2*p]) begin
          if (cnt32 == pr32) begin
            match[2*p+1] = 1'b1;
            nxt_count[p*32 +: 32] = 32'h0;
          end else begin
            nxt_count[p*32 +: 32] = cnt32 + 32'h1;
          end
        end
      end else begin
        // two independent halves
        if (cnt_tick[2*p]) begin
          if (COUNT[p*32 +: 16] == PERIOD[p*32 +: 16]) begin
            match[2*p] = 1'b1;
            nxt_count[p*32 +: 16] = `CTP_CNT_RST;
          end else begin
            nxt_count[p*32 +: 16] = COUNT[p*32 +: 16] + 16'h1;
          end
        end
        if (cnt_tick[2*p+1]) begin
          if (COUNT[p*32+16 +: 16] == PERIOD[p*32+16 +: 16]) begin
            match[2*p+1] = 1'b1;
            nxt_count[p*32+16 +: 16] = `CTP_CNT_RST;
          end else begin
            nxt_count[p*32+16 +: 16] = COUNT[p*32+16 +: 16] + 16'h1;
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  integer t;
  always @* begin
    for (t = 0; t < 4; t = t + 1) begin
      // gated mode flags at gate fall instead of at match
      if (ctl_all[t*16 + `CTP_CTL_GATE])
        nxt_irq[t] = gate_fall[t];
      else
        nxt_irq[t] = match[t];
    end
    // 32-bit pair: the low half never flags
    if (mode32[0]) begin
      nxt_irq[1] = PAIR_A_LOW_CONTROL[`CTP_CTL_GATE] ? gate_fall[0] :
                   match[1];
      nxt_irq[0] = 1'b0;
    end
    if (mode32[1]) begin
      nxt_irq[3] = PAIR_B_LOW_CONTROL[`CTP_CTL_GATE] ? gate_fall[2] :
                   match[3];
      nxt_irq[2] = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always @(posedge CLK) begin
    if (SYS_RST) begin
      COUNT          <= 64'h0;
      IRQ_FLAG       <= 4'h0;
      DMA_REQ        <= 4'h0;
      CC_TICK_A_LOW  <= 1'b0;
      CC_TICK_A_HIGH <= 1'b0;
      CONV_TRIG      <= 1'b0;
    end else begin
      COUNT    <= nxt_count;
      IRQ_FLAG <= nxt_irq;
      DMA_REQ  <= nxt_irq;
      // time base ticks only from pair a
      CC_TICK_A_LOW  <= cnt_tick[0];
      CC_TICK_A_HIGH <= mode32[0] ? cnt_tick[0] : cnt_tick[1];
      // pair a high timer or pair a as 32-bit
      CONV_TRIG <= nxt_irq[1];
    end
  end
endmodule // ctp_timer_pairs

// File: dv/ctp_timer_pairs_props.sv
// property checker for the timer pairs
`timescale 1ns/1ps
module ctp_timer_pairs_props (
  // clock and reset
  input wire        CLK,
  input wire        SYS_RST,
  // watched ports
  input wire [15:0] PAIR_A_LOW_CONTROL,
  input wire [63:0] COUNT,
  input wire [3:0]  IRQ_FLAG,
  input wire [3:0]  DMA_REQ,
  input wire        CC_TICK_A_LOW,
  input wire        CONV_TRIG
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  sequence s_off4; (!PAIR_A_LOW_CONTROL[0])[*4]; endsequence
  sequence s_a32; PAIR_A_LOW_CONTROL[5][*3]; endsequence
  wire a16 = !PAIR_A_LOW_CONTROL[5];
  dma_mirror_a: assert property (DMA_REQ == IRQ_FLAG)
    else $error("dma request differs from flag");
  conv_src_a: assert property (CONV_TRIG == IRQ_FLAG[1])
    else $error("converter trigger differs");
  low_flag_quiet_a: assert property (s_a32 |-> !IRQ_FLAG[0])
    else $error("low flag pulsed while paired");
  wrap_irq_a: assert property ($past(!SYS_RST) && a16 &&
    COUNT[15:0] == 16'h0 && $past(COUNT[15:0]) != 16'h0 |-> ##[0:2] IRQ_FLAG[0])
    else $error("wrap without flag");
  count_step_a: assert property ($changed(COUNT[15:0]) && a16 |->
    COUNT[15:0] == $past(COUNT[15:0]) + 16'h1 || COUNT[15:0] == 16'h0)
    else $error("count skipped");
  off_hold_a: assert property (s_off4 |-> $stable(COUNT[15:0]))
    else $error("count moved while off");
  // only a paired high word has to wait for the low word to carry
  msw_carry_a: assert property (!a16 && $changed(COUNT[31:16]) |->
    COUNT[15:0] == 16'h0) else $error("msw moved without carry");
  // tick and count leave the same edge, so they show together
  cc_tick_a: assert property ($past(!SYS_RST) && a16 &&
    $changed(COUNT[15:0]) |-> CC_TICK_A_LOW)
    else $error("count moved without tick");
endmodule // ctp_timer_pairs_props

// File: dv/ctp_far_side.sv
// far side: converter and dma request tallies
`timescale 1ns/1ps
module ctp_far_side (
  // clock and reset
  input  wire         clk,
  input  wire         rst,
  // events
  input  wire  [3:0]  dma_req,
  input  wire         conv_trig,
  // tallies
  output logic [7:0]  n_dma [4],
  output logic [7:0]  n_conv
);
  always @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      n_dma[i] <= rst ? 8'h00 : n_dma[i] + {7'h0, dma_req[i]};
    end
    n_conv <= rst ? 8'h00 : n_conv + {7'h0, conv_trig};
  end
endmodule // ctp_far_side

// File: dv/tb_cascadable_timer_pair.sv
// self-checking bench for the timer pairs
`timescale 1ns/1ps
module tb_cascadable_timer_pair;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        idle = 1'b0;
  logic [15:0] ctl [4] = '{default: 16'h0000};
  logic [63:0] per = 64'h0;
  logic [3:0]  ext = 4'h0;
  logic [3:0]  gate = 4'h0;
  logic [63:0] cnt;
  logic [3:0]  irq;
  logic [3:0]  dma;
  logic        cc_lo;
  logic        cc_hi;
  logic        conv;
  logic [7:0]  n_dma [4];
  logic [7:0]  n_conv;
  logic [31:0] seed = 32'd16619;
  logic [31:0] r;
  logic [15:0] p;
  int          n_fail = 0;
  int          samples_checked = 0;
  int          t;
  always #4 clk = ~clk;
  ctp_timer_pairs u_dut (.CLK(clk), .SYS_RST(rst), .IDLE_MODE(idle),
    .PAIR_A_LOW_CONTROL(ctl[0]), .PAIR_A_HIGH_CONTROL(ctl[1]),
    .PAIR_B_LOW_CONTROL(ctl[2]), .PAIR_B_HIGH_CONTROL(ctl[3]),
    .PERIOD(per), .EXT_CLK(ext), .GATE_IN(gate), .COUNT(cnt),
    .IRQ_FLAG(irq), .DMA_REQ(dma), .CC_TICK_A_LOW(cc_lo),
    .CC_TICK_A_HIGH(cc_hi), .CONV_TRIG(conv));
  ctp_far_side u_far (.clk(clk), .rst(rst), .dma_req(dma),
    .conv_trig(conv), .n_dma(n_dma), .n_conv(n_conv));
  function logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // cycles between period matches
  function logic [31:0] iv(input logic [15:0] pr, input logic [1:0] ps);
    return ({16'h0, pr} + 32'h1) << (ps == 2'h0 ? 0 : ps == 2'h1 ? 3 :
      ps == 2'h2 ? 6 : 8);
  endfunction
  task chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task reset_dut();
    @(posedge clk);
    rst <= 1'b1;
    ctl <= '{default: 16'h0000};
    ext <= 4'h0;
    gate <= 4'h0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
  endtask
  task wait_irq(input int i);
    t = 0;
    do begin
      @(negedge clk);
      t++;
    end while (irq[i] !== 1'b1 && t < 70000);
    // a flag that never comes is a failure, not a quiet exit
    if (irq[i] !== 1'b1) n_fail++;
  endtask
  task stop_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    #720000;
    n_fail++;
    stop_test();
  end
  initial begin
    // each timer alone, each prescale ratio once; idle has no hold here
    for (int i = 0; i < 4; i++) begin
      reset_dut();
      r = rnd();
      p = {13'h0, r[2:0]} + 16'h1;
      per <= {4{p}};
      idle <= r[8];
      ctl[i] <= {11'h0, i[1:0], 3'h1};
      wait_irq(i);
      wait_irq(i);
      chk(t, iv(p, i[1:0]));
      @(negedge clk);
      chk(n_dma[i], 2);
      chk(n_conv, (i == 1) ? 2 : 0);
      $display("test single %0d done", i);
    end
    // paired, high control and pins randomised to show they are ignored
    reset_dut();
    r = rnd();
    per <= {48'h0, 8'h0, r[7:0] | 8'h1};
    ctl[0] <= 16'h0021;
    ctl[1] <= r[31:16];
    ext <= {2'h0, r[9], 1'b0};
    gate <= {2'h0, r[10], 1'b0};
    wait_irq(1);
    wait_irq(1);
    chk(t, {24'h0, r[7:0] | 8'h1} + 32'h1);
    chk(n_dma[0], 0);
    $display("test pair small done");
    // carry into the high word
    reset_dut();
    per <= {32'h0, 32'h0001_0000};
    ctl[0] <= 16'h0021;
    wait_irq(1);
    chk(t >= 65537 && t <= 65545, 1);
    $display("test pair carry done");
    // gated count on pair b low
    reset_dut();
    r = rnd();
    per <= 64'hffff_ffff_ffff_ffff;
    ctl[2] <= 16'h0003;
    repeat (3) @(posedge clk);
    gate[2] <= 1'b1;
    repeat (r[3:0] + 3) @(posedge clk);
    gate[2] <= 1'b0;
    repeat (6) @(negedge clk);
    chk(cnt[47:32], r[3:0] + 3);
    chk(n_dma[2], 1);
    $display("test gate done");
    // external edges on pair b high
    reset_dut();
    ctl[3] <= 16'h0005;
    repeat (r[6:4] + 2) begin
      repeat (3) @(posedge clk);
      ext[3] <= 1'b1;
      repeat (3) @(posedge clk);
      ext[3] <= 1'b0;
    end
    repeat (6) @(negedge clk);
    chk(cnt[63:48], r[6:4] + 2);
    $display("test ext done");
    // idle: stop bit holds one timer, the other runs on
    reset_dut();
    idle <= 1'b1;
    ctl[0] <= 16'h0041;
    ctl[1] <= 16'h0001;
    repeat (20) @(negedge clk);
    chk(cnt[15:0], 0);
    chk(cnt[31:16] != 16'h0, 1);
    chk(cc_lo, 0);
    chk(cc_hi, 1);
    $display("test idle done");
    stop_test();
  end
endmodule // tb_cascadable_timer_pair
bind ctp_timer_pairs ctp_timer_pairs_props u_props (.CLK, .SYS_RST,
  .PAIR_A_LOW_CONTROL, .COUNT, .IRQ_FLAG, .DMA_REQ, .CC_TICK_A_LOW,
  .CONV_TRIG);
